// *** rtl/drc_defs.vh ***
// Command codes, field positions, reset values and timing for drc_regs
`ifndef DRC_DEFS_VH
`define DRC_DEFS_VH

// Read and write command codes
`define DRC_RD_CONTROL      8'h62
`define DRC_WR_CONTROL      8'he2
`define DRC_RD_STATUS       8'h67
`define DRC_RD_EVENT_FLAGS  8'h68
`define DRC_WR_EVENT_FLAGS  8'he8
`define DRC_RD_EVENT_MASK   8'h69
`define DRC_WR_EVENT_MASK   8'he9
`define DRC_RD_TIMER        8'h6a
`define DRC_WR_TIMER        8'hea
`define DRC_RD_ALT_TIMER    8'h6c
`define DRC_WR_ALT_TIMER    8'hec

// Control register layout
`define DRC_CTRL_RESET      16'h01c0
`define DRC_CTRL_WR_MASK    16'h0fff
`define DRC_CTRL_SE0_EN     11
`define DRC_CTRL_SRP_DET_EN 10
`define DRC_CTRL_SRP_METHOD 9
`define DRC_CTRL_ENG_SEL    8
`define DRC_CTRL_DM_PD      7
`define DRC_CTRL_DP_PD      6
`define DRC_CTRL_DP_PU      4

// Event flag bit positions
`define DRC_EVT_SRP_DET     0
`define DRC_EVT_RMT_CONN    1

// Status bit that shows a bus reset in progress
`define DRC_STAT_SE0_BUSY   0

// Bus reset length on remote connect, and its cycle count at 50 MHz
`define DRC_CLK_MHZ         50
`define DRC_SE0_TIME_US     10000
`define DRC_SE0_CYCLES      (`DRC_SE0_TIME_US * `DRC_CLK_MHZ)

`endif

// *** rtl/drc_pin_sync.v ***
// Two-stage synchroniser with rising-edge pulse for asynchronous pins
`timescale 1ns/100ps
`default_nettype none

module drc_pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             core_clk_in,
  input  wire             rst_in,
  input  wire [WIDTH-1:0] pins_in,
  output wire [WIDTH-1:0] level_out,
  output wire [WIDTH-1:0] rise_out
);

  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;
  reg [WIDTH-1:0] prev_ff;

  // First stage feeds only the second; edges are taken after stage two
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
      prev_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= pins_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level_out = sync_ff;
  assign rise_out  = sync_ff & ~prev_ff;

endmodule
`default_nettype wire

// *** rtl/drc_regs.v ***
// Dual-role port control register bank reached by command codes
`timescale 1ns/100ps
`default_nettype none
`include "drc_defs.vh"

// Summary of operation
// - Control register is 16 bits, read by code 62h, written by E2h.
// - Status 67h read-only; flags 68h/E8h, mask 69h/E9h, timers 6Ah/6Ch.
// - Control resets with bits 8,7,6 set and all others clear.
// - Bit 11 set: send bus reset when a remote connect is detected.
// - Bit 10 set lets a detected session request set its event flag.
// - Bit 9 picks session request sensing: VBUS pulse or data line pulse.
// - Bit 8 routes transceiver: 0 host engine, 1 peripheral engine.
// - Bit 7 connects the DM pull-down resistor when one.
// - Bit 6 connects the DP pull-down resistor when one.
// - Bit 4 connects the DP pull-up resistor when one.
module drc_regs #(
  parameter SE0_CYCLES = `DRC_SE0_CYCLES
) (
  input  wire        core_clk_in,
  input  wire        rst_in,
  input  wire        cmd_valid_in,
  input  wire [7:0]  cmd_code_in,
  input  wire [31:0] cmd_wdata_in,
  output reg  [31:0] rd_data_out,
  output reg         rd_valid_out,
  output reg         cmd_error_out,
  input  wire        remote_connect_in,
  input  wire        vbus_pulse_in,
  input  wire        dline_pulse_in,
  input  wire [14:0] status_pins_in,
  output reg         engine_select_out,
  output reg         dminus_pulldown_connect_out,
  output reg         dplus_pulldown_connect_out,
  output reg         dplus_pullup_connect_out,
  output reg         aux_control_out_unused_out,
  output reg  [3:0]  power_control_out,
  output reg         bus_reset_se0_out
);

  reg  [15:0] dual_role_control_ff;
  reg  [15:0] dual_role_event_flags_ff;
  reg  [15:0] dual_role_event_mask_ff;
  reg  [31:0] dual_role_timer_ff;
  reg  [31:0] dual_role_alt_timer_ff;
  reg  [31:0] se0_count_ff;
  reg  [15:0] nxt_flags;
  reg  [31:0] nxt_rd_data;
  reg         nxt_rd_valid;
  reg         nxt_error;
  wire [17:0] pin_level;
  wire [17:0] pin_rise;
  wire [15:0] status_word;
  wire        wr_ctrl;
  wire        wr_flags;
  wire        srp_seen;
  wire        rmt_conn;

  // All pins are asynchronous to the core clock
  drc_pin_sync #(
    .WIDTH (18)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .pins_in     ({dline_pulse_in, vbus_pulse_in, remote_connect_in,
                   status_pins_in}),
    .level_out   (pin_level),
    .rise_out    (pin_rise)
  );

  // True when a command with the given code is presented this cycle
  function is_cmd;
    input       valid;
    input [7:0] code;
    input [7:0] want;
    begin
      is_cmd = valid && (code == want);
    end
  endfunction

  assign wr_ctrl  = is_cmd(cmd_valid_in, cmd_code_in, `DRC_WR_CONTROL);
  assign wr_flags = is_cmd(cmd_valid_in, cmd_code_in, `DRC_WR_EVENT_FLAGS);
  assign rmt_conn = pin_rise[15];

  // Session request sensing chosen by method bit
  assign srp_seen = dual_role_control_ff[`DRC_CTRL_SRP_METHOD] ?
                    pin_rise[17] : pin_rise[16];

  // Status shows pin levels and whether a bus reset is running
  assign status_word = {pin_level[14:0], (se0_count_ff != 32'h0000_0000)};

  // Control register; reserved bits masked off on write
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      dual_role_control_ff <= `DRC_CTRL_RESET;
    end else if (wr_ctrl) begin
      dual_role_control_ff <= cmd_wdata_in[15:0] & `DRC_CTRL_WR_MASK;
    end
  end

  // Mask and timers are plain storage for firmware
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      dual_role_event_mask_ff <= 16'h0000;
      dual_role_timer_ff      <= 32'h0000_0000;
      dual_role_alt_timer_ff  <= 32'h0000_0000;
    end else begin
      if (is_cmd(cmd_valid_in, cmd_code_in, `DRC_WR_EVENT_MASK)) begin
        dual_role_event_mask_ff <= cmd_wdata_in[15:0];
      end
      if (is_cmd(cmd_valid_in, cmd_code_in, `DRC_WR_TIMER)) begin
        dual_role_timer_ff <= cmd_wdata_in;
      end
      if (is_cmd(cmd_valid_in, cmd_code_in, `DRC_WR_ALT_TIMER)) begin
        dual_role_alt_timer_ff <= cmd_wdata_in;
      end
    end
  end

  // Event flags: write one to clear, a new event in the same cycle wins
  always @* begin
    nxt_flags = dual_role_event_flags_ff;
    if (wr_flags) begin
      nxt_flags = nxt_flags & ~cmd_wdata_in[15:0];
    end
    if (srp_seen && dual_role_control_ff[`DRC_CTRL_SRP_DET_EN]) begin
      nxt_flags[`DRC_EVT_SRP_DET] = 1'b1;
    end
    if (rmt_conn) begin
      nxt_flags[`DRC_EVT_RMT_CONN] = 1'b1;
    end
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      dual_role_event_flags_ff <= 16'h0000;
    end else begin
      dual_role_event_flags_ff <= nxt_flags;
    end
  end

  // Bus reset timer: a remote connect with bit 11 set starts SE0.
  // A connect seen while SE0 already runs does not restart it.
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      se0_count_ff <= 32'h0000_0000;
    end else if (se0_count_ff != 32'h0000_0000) begin
      se0_count_ff <= se0_count_ff - 32'h0000_0001;
    end else if (rmt_conn && dual_role_control_ff[`DRC_CTRL_SE0_EN]) begin
      se0_count_ff <= SE0_CYCLES;
    end
  end

  // Read mux and command answer, one cycle after the command
  always @* begin
    nxt_rd_data  = 32'h0000_0000;
    nxt_rd_valid = 1'b0;
    nxt_error    = 1'b0;
    if (cmd_valid_in) begin
      case (cmd_code_in)
        `DRC_RD_CONTROL: begin
          nxt_rd_data  = {16'h0000, dual_role_control_ff};
          nxt_rd_valid = 1'b1;
        end
        `DRC_RD_STATUS: begin
          nxt_rd_data  = {16'h0000, status_word};
          nxt_rd_valid = 1'b1;
        end
        `DRC_RD_EVENT_FLAGS: begin
          nxt_rd_data  = {16'h0000, dual_role_event_flags_ff};
          nxt_rd_valid = 1'b1;
        end
        `DRC_RD_EVENT_MASK: begin
          nxt_rd_data  = {16'h0000, dual_role_event_mask_ff};
          nxt_rd_valid = 1'b1;
        end
        `DRC_RD_TIMER: begin
          nxt_rd_data  = dual_role_timer_ff;
          nxt_rd_valid = 1'b1;
        end
        `DRC_RD_ALT_TIMER: begin
          nxt_rd_data  = dual_role_alt_timer_ff;
          nxt_rd_valid = 1'b1;
        end
        `DRC_WR_CONTROL, `DRC_WR_EVENT_FLAGS, `DRC_WR_EVENT_MASK,
        `DRC_WR_TIMER, `DRC_WR_ALT_TIMER: begin
          nxt_error = 1'b0;
        end
        default: begin
          nxt_error = 1'b1; // Unknown code, status has no write code
        end
      endcase
    end
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      rd_data_out   <= 32'h0000_0000;
      rd_valid_out  <= 1'b0;
      cmd_error_out <= 1'b0;
    end else begin
      rd_data_out   <= nxt_rd_data;
      rd_valid_out  <= nxt_rd_valid;
      cmd_error_out <= nxt_error;
    end
  end

  // Pin controls registered so they follow the control word, and SE0 the bus reset timer, by one cycle
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      engine_select_out           <= 1'b1;
      dminus_pulldown_connect_out <= 1'b1;
      dplus_pulldown_connect_out  <= 1'b1;
      dplus_pullup_connect_out    <= 1'b0;
      aux_control_out_unused_out  <= 1'b0;
      power_control_out           <= 4'h0;
      bus_reset_se0_out           <= 1'b0;
    end else begin
      engine_select_out <= dual_role_control_ff[`DRC_CTRL_ENG_SEL];
      dminus_pulldown_connect_out <=
        dual_role_control_ff[`DRC_CTRL_DM_PD];
      dplus_pulldown_connect_out <=
        dual_role_control_ff[`DRC_CTRL_DP_PD];
      dplus_pullup_connect_out <=
        dual_role_control_ff[`DRC_CTRL_DP_PU];
      aux_control_out_unused_out <= dual_role_control_ff[5];
      power_control_out <= dual_role_control_ff[3:0];
      bus_reset_se0_out <= (se0_count_ff != 32'h0000_0000);
    end
  end

endmodule
`default_nettype wire

// *** dv/drc_regs_checker.sv ***
// Assertions on the command port and pin outputs of drc_regs
`timescale 1ns/100ps
`default_nettype none
module drc_regs_checker (
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic        cmd_valid_in,
  input wire logic [7:0]  cmd_code_in,
  input wire logic [31:0] cmd_wdata_in,
  input wire logic        rd_valid_out,
  input wire logic        cmd_error_out,
  input wire logic        engine_select_out,
  input wire logic        dminus_pulldown_connect_out,
  input wire logic        dplus_pulldown_connect_out,
  input wire logic        dplus_pullup_connect_out,
  input wire logic        bus_reset_se0_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  wire  wr_ctl = cmd_valid_in && cmd_code_in == 8'he2;
  logic se0_en_ff;
  // Shadow of the bus reset enable, since the checker cannot see control
  always @(posedge core_clk_in) begin
    if (rst_in) se0_en_ff <= 1'b0;
    else if (wr_ctl) se0_en_ff <= cmd_wdata_in[11];
  end
  // Pins trail the control write by two edges
  property p_pin(int b, logic o);
    wr_ctl |=> ##1 o == $past(cmd_wdata_in[b], 2);
  endproperty
  chk_read_answer: assert property (
    cmd_valid_in && cmd_code_in == 8'h62 |=> rd_valid_out && !cmd_error_out)
    else $error("control read not answered");
  chk_status_nowrite: assert property (
    cmd_valid_in && cmd_code_in == 8'he7 |=> cmd_error_out && !rd_valid_out)
    else $error("status write not refused");
  chk_reset_pins: assert property ($fell(rst_in) |->
    engine_select_out && dminus_pulldown_connect_out &&
    dplus_pulldown_connect_out && !dplus_pullup_connect_out)
    else $error("pin outputs wrong after reset");
  chk_pin_engine: assert property (p_pin(8, engine_select_out))
    else $error("engine select does not follow control");
  chk_pin_dmpd: assert property (p_pin(7, dminus_pulldown_connect_out))
    else $error("dm pull-down does not follow control");
  chk_pin_dppd: assert property (p_pin(6, dplus_pulldown_connect_out))
    else $error("dp pull-down does not follow control");
  chk_pin_dppu: assert property (p_pin(4, dplus_pullup_connect_out))
    else $error("dp pull-up does not follow control");
  // Counter loads two edges before the pin rises, so look back that far
  chk_se0_enable: assert property (
    $rose(bus_reset_se0_out) |-> $past(se0_en_ff, 2))
    else $error("bus reset started while disabled");
  cover property (wr_ctl);
  cover property (cmd_error_out);
  cover property ($rose(bus_reset_se0_out));
endmodule
bind drc_regs drc_regs_checker chk (
  .core_clk_in                 (core_clk_in),
  .rst_in                      (rst_in),
  .cmd_valid_in                (cmd_valid_in),
  .cmd_code_in                 (cmd_code_in),
  .cmd_wdata_in                (cmd_wdata_in),
  .rd_valid_out                (rd_valid_out),
  .cmd_error_out               (cmd_error_out),
  .engine_select_out           (engine_select_out),
  .dminus_pulldown_connect_out (dminus_pulldown_connect_out),
  .dplus_pulldown_connect_out  (dplus_pulldown_connect_out),
  .dplus_pullup_connect_out    (dplus_pullup_connect_out),
  .bus_reset_se0_out           (bus_reset_se0_out)
);
`default_nettype wire

// *** dv/drc_remote_dev.sv ***
// Far-side device model raising connect and session request pulses
`timescale 1ns/100ps
`default_nettype none
module drc_remote_dev (
  output logic [2:0] pins_out // 2 connect, 1 data line, 0 VBUS
);
  initial pins_out = 3'h0;
  // Rise off the clock grid, fall on a rising clock edge; wider than the two-flop synchroniser needs
  task automatic pulse(input int i);
    #13 pins_out[i] = 1'b1;
    #97 pins_out[i] = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the dual-role control register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk, rst, vld, rdv, err, eng, dmp, dpp, dpu, aux, se0;
  logic [7:0]  code;
  logic [31:0] wd, rdd, w;
  logic [3:0]  pwr;
  logic [14:0] stp;
  logic [2:0]  pins;
  logic [32:0] q[$];
  logic [7:0]  tbl[3] = '{8'h69, 8'h6a, 8'h6c};
  int          errors, checks_done, c;
  drc_regs #(.SE0_CYCLES(20)) uut (
    .core_clk_in(clk), .rst_in(rst), .cmd_valid_in(vld),
    .cmd_code_in(code), .cmd_wdata_in(wd), .rd_data_out(rdd),
    .rd_valid_out(rdv), .cmd_error_out(err),
    .remote_connect_in(pins[2]), .vbus_pulse_in(pins[0]),
    .dline_pulse_in(pins[1]), .status_pins_in(stp),
    .engine_select_out(eng), .dminus_pulldown_connect_out(dmp),
    .dplus_pulldown_connect_out(dpp), .dplus_pullup_connect_out(dpu),
    .aux_control_out_unused_out(aux), .power_control_out(pwr),
    .bus_reset_se0_out(se0));
  drc_remote_dev rem (.pins_out(pins));
  task chk(input string nm, input [32:0] e, input [32:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // Strobe stays up between back-to-back commands
  task cmd(input [7:0] cd, input [31:0] d);
    vld = 1'b1; code = cd; wd = d;
    @(negedge clk);
  endtask
  task idle(input int k);
    vld = 1'b0;
    repeat (k) @(negedge clk);
  endtask
  task rd(input [7:0] cd, input [32:0] e);
    q.push_back(e);
    cmd(cd, $urandom);
  endtask
  task pinchk(input [11:0] v);
    chk("pins", v[8:0], {eng, dmp, dpp, aux, dpu, pwr});
  endtask
  task count_se0(output int n);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      n += (se0 === 1'b1);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Each answer pulse takes the oldest expectation; sampled at the
  // falling edge so the registered answer has settled
  always @(negedge clk) begin
    if (rdv === 1'b1 || err === 1'b1) chk("answer", q.pop_front(), {err, rdd});
  end
  initial begin
    #1000000;
    errors++;
    end_of_test;
  end
  initial begin
    vld = 0; code = 0; wd = 0; rst = 1; stp = 0; errors = 0; checks_done = 0;
    w = $urandom(61);
    repeat (12) @(negedge clk);
    rst = 0;
    pinchk(12'h1c0);
    rd(8'h62, 33'h1c0);
    repeat (6) begin
      w = $urandom;
      w[11] = 1'b0; // Bus reset kept off until the connect test
      cmd(8'he2, w);
      rd(8'h62, {21'h0, w[11:0]});
      idle(1);
      pinchk(w[11:0]);
    end
    foreach (tbl[i]) begin
      w = $urandom;
      cmd(tbl[i] | 8'h80, w);
      rd(tbl[i], tbl[i] < 8'h6a ? w & 32'hffff : w);
    end
    stp = 15'($urandom);
    idle(3);
    rd(8'h67, {stp, 1'b0});
    rd(8'he7, 33'h100000000);
    rd(8'h00, 33'h100000000);
    for (int k = 0; k < 8; k++) begin
      cmd(8'he2, {21'h0, k[2], k[1], 9'h1c0});
      cmd(8'he8, 32'hffff);
      idle(1);
      rem.pulse(k[0]);
      idle(6);
      rd(8'h68, k[2] && k[1] == k[0]);
    end
    cmd(8'he8, 32'hffff);
    idle(1);
    fork rem.pulse(2); count_se0(c); join
    chk("se0 off", 0, c);
    rd(8'h68, 33'h2);
    cmd(8'he2, 32'h1c0);
    idle(2500);
    cmd(8'he2, 32'h9c0);
    cmd(8'he2, 32'h8c0);
    idle(1);
    pinchk(12'h8c0);
    fork rem.pulse(2); count_se0(c); join
    chk("se0 len", 20, c);
    idle(3);
    chk("pending", 0, q.size());
    end_of_test;
  end
endmodule
`default_nettype wire
